// File: verilog/reset_sequencer.sv
// Reset sequencer with supply integrity control and status, APB slave
// Assumes an APB master on SYS_CLK_I and an open-drain reset pin resolved
// outside; option bits are static after power-on.
//
// Functional notes
// - All sources pull pin; low throughout delay.
// - Fetch start vector from top two bytes.
// - Active, then 256/4096 delay, then fetch.
// - Vector fetch lasts exactly two cycles.
// - Oscillator keeps running throughout reset.
// - Pin low caught without clock.
// - Reset pin is input and open-drain output.
// - Watchdog underflow drives pin for minimum width.
// - Undervoltage holds pin low until released.
// - Undervoltage reset optional, three threshold levels.
// - Warning logic inactive without undervoltage option.
// - Warning flag real time, not writable.
// - Interrupt on every warning flag change.
// - Interrupt needs enable and cleared CPU mask.
// - No warning interrupt for crossing during delay.
// - Enabling below threshold gives an interrupt.
// - Warning wakes from Wait, never from Halt.
// - Integrity register frozen during Halt.
// - Clock source chosen among six options.
// - Enable bit 6, flag bit 5; ack clears.
// - Undervoltage flag set by hardware, cleared by zero.
// - Watchdog flag cleared by zero or undervoltage.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "rst_seq_map.svh"

module reset_sequencer
(
    input  wire logic                  SYS_CLK_I,
    input  wire logic                  RST_I,
    input  wire rst_seq_pkg::apb_req_s APB_REQ_I,
    output rst_seq_pkg::apb_rsp_s      APB_RSP_O,
    input  wire logic                  RST_PIN_I,
    output logic                       RST_PIN_O,
    output logic                       RST_PIN_OE_O,
    input  wire rst_seq_pkg::option_s  OPTIONS_I,
    input  wire logic                  UV_DET_I,
    input  wire logic                  WARN_CMP_I,
    input  wire logic                  WDG_UNDERFLOW_I,
    input  wire logic                  CC_IMASK_I,
    input  wire logic                  WAIT_I,
    input  wire logic                  HALT_I,
    input  wire logic                  IRQ_ACK_I,
    output logic                       CPU_RESET_O,
    output logic                       VEC_FETCH_O,
    output logic [15:0]                VEC_ADDR_O,
    output logic                       WARN_IRQ_O,
    output logic                       WAKE_O,
    output logic                       OSC_RUN_O,
    output logic [5:0]                 CLK_SRC_SEL_O,
    output logic                       UV_DET_EN_O,
    output logic [1:0]                 UV_LEVEL_O
);
    import rst_seq_pkg::*;

    // ======================================================================
    // State
    typedef struct packed
    {
        seq_e        seq;
        logic [12:0] cnt;
        logic        wdg_hold;
        logic [1:0]  pin_sync;
        logic [2:0]  guard;
        logic        drive;
        logic        warn_flag;
        logic        warn_en;
        logic        warn_pend;
        logic        uv_flag;
        logic        wdg_flag;
        apb_rsp_s    rsp;
        logic        cpu_rst;
        logic        vec_fetch;
        logic [15:0] vec_addr;
        logic        irq;
        logic        wake;
        logic        osc_run;
        logic [5:0]  clk_sel;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic   pin_low_q;

    // ======================================================================
    // Functions
    function automatic logic [5:0] src_decode(input logic [2:0] code);
        logic [5:0] sel;
        sel = 6'h00;
        if (code == `SRC_INT_RC)
            sel = 6'h20;
        else if (code >= `SRC_RES_FIRST && code <= `SRC_RES_LAST)
            sel = 6'h01 << code;
        else
            sel = 6'h01;
        return sel;
    endfunction

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    // ======================================================================
    // Asynchronous pin capture, then two-stage synchroniser
    always_ff @(posedge SYS_CLK_I or negedge RST_PIN_I)
    begin
        if (!RST_PIN_I)
            pin_low_q <= 1'b1;
        else
            pin_low_q <= 1'b0;
    end

    // ======================================================================
    // Next-state logic
    logic        uv_src;
    logic        wdg_src;
    logic        ext_src;
    logic        in_rst;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        warn_raw;
    logic        set_pend;
    logic [12:0] dly_last;
    logic [31:0] rdata;

    always_comb
    begin
        s_d = s_q;
        uv_src  = UV_DET_I & OPTIONS_I.uv_en;
        wdg_src = WDG_UNDERFLOW_I;
        // Own drive echoes on the pin; masked until it settles
        ext_src = s_q.pin_sync[1] & ~s_q.drive & (s_q.guard == 3'h0);
        dly_last = OPTIONS_I.long_delay ? (`LONG_DELAY_CYC - 13'h0001)
                                        : (`SHORT_DELAY_CYC - 13'h0001);
        s_d.pin_sync = {s_q.pin_sync[0], pin_low_q};
        s_d.guard    = (s_q.guard != 3'h0) ? s_q.guard - 3'h1 : 3'h0;

        // Sequencer
        case (s_q.seq)
            SEQ_ACTIVE:
            begin
                if (s_q.wdg_hold)
                begin
                    s_d.cnt = s_q.cnt + 13'h0001;
                    if (s_q.cnt == 13'(`RST_OUT_MIN_CYC - 1))
                        s_d.wdg_hold = 1'b0;
                end
                if (!uv_src && !ext_src && !s_d.wdg_hold)
                begin
                    s_d.seq = SEQ_DELAY;
                    s_d.cnt = 13'h0000;
                end
            end
            SEQ_DELAY:
            begin
                s_d.cnt = s_q.cnt + 13'h0001;
                if (s_q.cnt == dly_last)
                begin
                    s_d.seq = SEQ_FETCH;
                    s_d.cnt = 13'h0000;
                end
            end
            SEQ_FETCH:
            begin
                s_d.cnt = s_q.cnt + 13'h0001;
                if (s_q.cnt == `FETCH_CYC - 13'h0001)
                    s_d.seq = SEQ_RUN;
            end
            SEQ_RUN:
            begin
                s_d.cnt = 13'h0000;
            end
            default:
            begin
                s_d.seq = SEQ_ACTIVE;
            end
        endcase

        // Any source (re)starts the active phase
        if (uv_src || wdg_src || (ext_src && s_q.seq != SEQ_ACTIVE))
        begin
            if (s_q.seq != SEQ_ACTIVE || wdg_src)
                s_d.cnt = 13'h0000;
            s_d.seq = SEQ_ACTIVE;
            if (wdg_src)
                s_d.wdg_hold = 1'b1;
        end

        // Fetch outputs follow the next state so reset and fetch abut
        s_d.vec_fetch = (s_d.seq == SEQ_FETCH);
        s_d.vec_addr  = !s_d.vec_fetch ? 16'h0000
                      : (s_d.cnt == 13'h0000) ? `RESET_VECTOR_LO : `RESET_VECTOR_HI;

        // Pin drive: internal sources while active, always during delay
        s_d.drive = (s_d.seq == SEQ_DELAY) ||
                    (s_d.seq == SEQ_ACTIVE && (uv_src || s_d.wdg_hold));
        if (s_q.drive && !s_d.drive)
            s_d.guard = `PIN_GUARD_CYC;
        s_d.cpu_rst = (s_d.seq == SEQ_ACTIVE) || (s_d.seq == SEQ_DELAY);
        in_rst = s_q.seq != SEQ_RUN;

        // Reset source flags, set wins over software clear
        wr_acc   = APB_REQ_I.psel & APB_REQ_I.penable & s_q.rsp.pready & APB_REQ_I.pwrite;
        rd_acc   = APB_REQ_I.psel & APB_REQ_I.penable & ~s_q.rsp.pready & ~APB_REQ_I.pwrite;
        hit_ctrl = addr_hit(APB_REQ_I.paddr, `OFS_CTRL_STATUS);
        hit_stat = addr_hit(APB_REQ_I.paddr, `OFS_SEQ_STATUS);
        if (wr_acc && hit_ctrl && !HALT_I)
        begin
            if (!APB_REQ_I.pwdata[`BIT_UV_RST_FLAG])
                s_d.uv_flag = 1'b0;
            if (!APB_REQ_I.pwdata[`BIT_WDG_RST_FLAG])
                s_d.wdg_flag = 1'b0;
        end
        if (wdg_src)
            s_d.wdg_flag = 1'b1;
        if (uv_src)
        begin
            s_d.uv_flag  = 1'b1;
            s_d.wdg_flag = 1'b0;
        end

        // Supply warning, frozen in Halt
        warn_raw = WARN_CMP_I & OPTIONS_I.uv_en;
        set_pend = 1'b0;
        if (!HALT_I)
        begin
            s_d.warn_flag = warn_raw;
            if (!in_rst && s_q.warn_en && warn_raw != s_q.warn_flag)
                set_pend = 1'b1;
            if (wr_acc && hit_ctrl)
            begin
                s_d.warn_en = APB_REQ_I.pwdata[`BIT_WARN_IRQ_EN] & OPTIONS_I.uv_en;
                if (s_d.warn_en && !s_q.warn_en && s_q.warn_flag)
                    set_pend = 1'b1;
            end
            if (IRQ_ACK_I)
                s_d.warn_pend = 1'b0;
            if (set_pend)
                s_d.warn_pend = 1'b1;
        end
        if (s_d.cpu_rst || !OPTIONS_I.uv_en)
        begin
            s_d.warn_en   = 1'b0;
            s_d.warn_pend = 1'b0;
        end
        s_d.irq  = s_d.warn_pend & s_d.warn_en & ~CC_IMASK_I;
        s_d.wake = s_d.irq & WAIT_I & ~HALT_I;

        // Clock source; oscillator never stopped while in reset
        s_d.clk_sel = src_decode(OPTIONS_I.clk_src);
        s_d.osc_run = s_d.cpu_rst || (s_d.seq != SEQ_RUN) || !HALT_I;

        // APB slave, one wait state
        rdata = 32'h0000_0000;
        if (hit_ctrl)
        begin
            rdata[`BIT_WARN_IRQ_EN]  = s_q.warn_en;
            rdata[`BIT_WARN_FLAG]    = s_q.warn_flag;
            rdata[`BIT_UV_RST_FLAG]  = s_q.uv_flag;
            rdata[`BIT_WDG_RST_FLAG] = s_q.wdg_flag;
        end
        else if (hit_stat)
        begin
            rdata[1:0] = s_q.seq;
            rdata[2]   = OPTIONS_I.long_delay;
            rdata[3]   = OPTIONS_I.uv_en;
            rdata[5:4] = OPTIONS_I.uv_level;
            rdata[8:6] = OPTIONS_I.clk_src;
        end
        s_d.rsp.pready  = APB_REQ_I.psel & APB_REQ_I.penable & ~s_q.rsp.pready;
        s_d.rsp.pslverr = s_d.rsp.pready & ~hit_ctrl & ~hit_stat;
        if (rd_acc)
            s_d.rsp.prdata = rdata;
    end

    // ======================================================================
    // Registers
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            s_q           <= '0;
            s_q.seq       <= SEQ_ACTIVE;
            s_q.drive     <= 1'b1;
            s_q.cpu_rst   <= 1'b1;
            s_q.osc_run   <= 1'b1;
            s_q.clk_sel   <= 6'h01;
            s_q.uv_flag   <= 1'(`CTRL_STATUS_RESET >> `BIT_UV_RST_FLAG);
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // Outputs
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            UV_DET_EN_O <= 1'b0;
            UV_LEVEL_O  <= 2'h0;
        end
        else
        begin
            UV_DET_EN_O <= OPTIONS_I.uv_en;
            UV_LEVEL_O  <= OPTIONS_I.uv_level;
        end
    end

    assign APB_RSP_O     = s_q.rsp;
    assign RST_PIN_O     = 1'b0;
    assign RST_PIN_OE_O  = s_q.drive;
    assign CPU_RESET_O   = s_q.cpu_rst;
    assign VEC_FETCH_O   = s_q.vec_fetch;
    assign VEC_ADDR_O    = s_q.vec_addr;
    assign WARN_IRQ_O    = s_q.irq;
    assign WAKE_O        = s_q.wake;
    assign OSC_RUN_O     = s_q.osc_run;
    assign CLK_SRC_SEL_O = s_q.clk_sel;

    // ======================================================================
    // Checks
    chk_delay_drive: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (s_q.seq == SEQ_DELAY) |-> RST_PIN_OE_O)
        else $error("reset pin released during delay");

    chk_fetch_pair: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(VEC_FETCH_O) |-> (VEC_ADDR_O == 16'hfffe) ##1
        (VEC_FETCH_O && VEC_ADDR_O == 16'hffff) ##1 !VEC_FETCH_O)
        else $error("vector fetch not two cycles at top");

    chk_short_delay: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (s_q.seq == SEQ_DELAY && s_q.cnt == 13'h00ff && !OPTIONS_I.long_delay
         && !UV_DET_I && !WDG_UNDERFLOW_I) |=> (s_q.seq == SEQ_FETCH))
        else $error("short delay did not end at 256 cycles");

    chk_wdg_width: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        WDG_UNDERFLOW_I |=> RST_PIN_OE_O [*8])
        else $error("watchdog reset pulse too short");

    chk_uv_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (UV_DET_I && OPTIONS_I.uv_en) |=> (RST_PIN_OE_O && CPU_RESET_O))
        else $error("undervoltage did not hold reset pin");

    chk_flag_follow: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        !HALT_I |=> (s_q.warn_flag == $past(WARN_CMP_I && OPTIONS_I.uv_en)))
        else $error("warning flag not tracking comparator");

    chk_irq_gate: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        WARN_IRQ_O |-> (!$past(CC_IMASK_I) && s_q.warn_en))
        else $error("interrupt raised while masked or disabled");

    chk_no_rst_irq: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (s_q.seq != SEQ_RUN) |=> !s_q.warn_pend && !s_q.warn_en)
        else $error("warning pending during reset");

    chk_halt_freeze: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (HALT_I && s_q.seq == SEQ_RUN) ##1 (s_q.seq == SEQ_RUN)
        |-> $stable(s_q.warn_en) && $stable(s_q.warn_flag))
        else $error("integrity register changed in halt");

    chk_uv_flag: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (UV_DET_I && OPTIONS_I.uv_en) |=> (s_q.uv_flag && !s_q.wdg_flag))
        else $error("undervoltage reset flags wrong");

endmodule

// File: verilog/rst_seq_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 50 MHz system clock and 32-bit APB data
`ifndef RST_SEQ_MAP_SVH
`define RST_SEQ_MAP_SVH

// ==========================================================================
// Register map
`define OFS_CTRL_STATUS     12'h000
`define OFS_SEQ_STATUS      12'h004
`define BIT_WARN_IRQ_EN     6
`define BIT_WARN_FLAG       5
`define BIT_UV_RST_FLAG     4
`define BIT_WDG_RST_FLAG    0
`define CTRL_STATUS_RESET   32'h0000_0000

// ==========================================================================
// Reset sequence timing
`define CLK_PERIOD_NS       20
`define SHORT_DELAY_CYC     13'h0100
`define LONG_DELAY_CYC      13'h1000
`define FETCH_CYC           13'h0002
`define RST_OUT_MIN_NS      1000
`define RST_OUT_MIN_CYC     ((`RST_OUT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_GUARD_CYC       3'h4
`define RESET_VECTOR_LO     16'hfffe
`define RESET_VECTOR_HI     16'hffff

// ==========================================================================
// Clock source option codes
`define SRC_EXT_CLOCK       3'h0
`define SRC_RES_FIRST       3'h1
`define SRC_RES_LAST        3'h4
`define SRC_INT_RC          3'h5

`endif

// File: verilog/rst_seq_pkg.sv
// Types shared by the reset sequencer and its surroundings
// Assumes rst_seq_map.svh for all numeric constants except the seq_e state encodings
package rst_seq_pkg;

    typedef enum logic [1:0]
    {
        SEQ_RUN    = 2'b00,
        SEQ_ACTIVE = 2'b01,
        SEQ_DELAY  = 2'b10,
        SEQ_FETCH  = 2'b11
    } seq_e;

    typedef struct packed
    {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed
    {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

    typedef struct packed
    {
        logic       long_delay;
        logic       uv_en;
        logic [1:0] uv_level;
        logic [2:0] clk_src;
    } option_s;

endpackage

// File: testbench/board_reset_model.sv
// Board-side model of the shared reset line and the external reset circuit
// Assumes the device pulls the line low through an open-drain enable
`timescale 1ns/100ps

module board_reset_model
(
    input  wire logic oe_i,
    input  wire logic data_i,
    input  wire logic ext_pull_i,
    output logic      line_o,
    output logic      board_rst_o
);
    // ==========================================================================
    // Wired-and line with weak pull-up
    assign line_o      = ((oe_i && !data_i) || ext_pull_i) ? 1'b0 : 1'b1;
    assign board_rst_o = !line_o;
endmodule

// File: testbench/reset_sequencer_tb.sv
// Self-checking bench: APB registers, reset sources, sequence, warning irq
// Assumes board_reset_model resolves the reset line
`timescale 1ns/100ps
`include "rst_seq_map.svh"

module reset_sequencer_tb;
    import rst_seq_pkg::*;

    typedef struct packed
    {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
    } exp_s;

    logic        sys_clk  = 1'b0;
    logic        rst      = 1'b1;
    apb_req_s    apb_req  = '0;
    apb_rsp_s    apb_rsp;
    logic        pin_line;
    logic        pin_data;
    logic        pin_oe;
    logic        board_rst;
    logic        ext_pull = 1'b0;
    option_s     opts     = '{1'b0, 1'b1, 2'h2, 3'h2};
    logic        uv_det   = 1'b0;
    logic        warn_cmp = 1'b0;
    logic        wdg      = 1'b0;
    logic        cc_mask  = 1'b0;
    logic        wait_i   = 1'b0;
    logic        halt     = 1'b0;
    logic        irq_ack  = 1'b0;
    logic        cpu_reset;
    logic        vec_fetch;
    logic [15:0] vec_addr;
    logic        irq;
    logic        wake;
    logic        osc_run;
    logic [5:0]  clk_sel;
    logic        uv_det_en;
    logic [1:0]  uv_lvl;
    exp_s        exp_q[$];
    exp_s        mon_e;
    logic [11:0] bad_addr;
    int          fails       = 0;
    int          checks_done = 0;
    int          cyc         = 0;

    always #(`CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

    reset_sequencer reset_sequencer_inst
    (
        .SYS_CLK_I       (sys_clk),
        .RST_I           (rst),
        .APB_REQ_I       (apb_req),
        .APB_RSP_O       (apb_rsp),
        .RST_PIN_I       (pin_line),
        .RST_PIN_O       (pin_data),
        .RST_PIN_OE_O    (pin_oe),
        .OPTIONS_I       (opts),
        .UV_DET_I        (uv_det),
        .WARN_CMP_I      (warn_cmp),
        .WDG_UNDERFLOW_I (wdg),
        .CC_IMASK_I      (cc_mask),
        .WAIT_I          (wait_i),
        .HALT_I          (halt),
        .IRQ_ACK_I       (irq_ack),
        .CPU_RESET_O     (cpu_reset),
        .VEC_FETCH_O     (vec_fetch),
        .VEC_ADDR_O      (vec_addr),
        .WARN_IRQ_O      (irq),
        .WAKE_O          (wake),
        .OSC_RUN_O       (osc_run),
        .CLK_SRC_SEL_O   (clk_sel),
        .UV_DET_EN_O     (uv_det_en),
        .UV_LEVEL_O      (uv_lvl)
    );

    board_reset_model board_reset_model_inst
    (
        .oe_i        (pin_oe),
        .data_i      (pin_data),
        .ext_pull_i  (ext_pull),
        .line_o      (pin_line),
        .board_rst_o (board_rst)
    );

    // ==========================================================================
    // Checking helpers
    task automatic print_verdict();
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg, input bit stop = 1'b0);
        checks_done++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("MISMATCH %0t %s", $time, msg);
            if (stop)
                print_verdict();
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Setup, access until pready, release, one idle cycle
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       input logic [31:0] rdata, input logic [31:0] mask, input logic err);
        int n;
        exp_q.push_back('{rdata, wr ? 32'h0 : mask, err});
        apb_req <= '{1'b1, 1'b0, wr, addr, wdata};
        tick(1);
        apb_req.penable <= 1'b1;
        n = 0;
        do
        begin
            tick(1);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        chk(apb_rsp.pready === 1'b1, "no pready", 1'b1);
        apb_req <= '0;
        tick(1);
    endtask

    always @(posedge sys_clk)
    begin
        if (apb_rsp.pready === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(1'b0, "unexpected answer");
            else
            begin
                mon_e = exp_q.pop_front();
                chk(((apb_rsp.prdata & mon_e.mask) === (mon_e.data & mon_e.mask))
                    && apb_rsp.pslverr === mon_e.err, "apb answer");
            end
        end
    end

    // Delay length counted from entry, reset held until fetch, two fetch cycles
    task automatic wait_fetch(input int lo);
        int   n;
        logic held;
        n    = 0;
        held = 1'b1;
        while (vec_fetch !== 1'b1 && n < lo + 14)
        begin
            // After an external pull, own drive starts with the delay
            if (n >= 2)
                held &= (pin_oe === 1'b1 || n < 5) && (cpu_reset === 1'b1)
                        && (osc_run === 1'b1);
            tick(1);
            n++;
        end
        chk(held, "reset not held");
        chk(n >= lo && n <= lo + 12, "delay length", 1'b1);
        chk(vec_addr === `RESET_VECTOR_LO, "vector low");
        tick(1);
        chk(vec_fetch === 1'b1 && vec_addr === `RESET_VECTOR_HI, "vector high");
        tick(1);
        chk(vec_fetch === 1'b0 && cpu_reset === 1'b0 && pin_oe === 1'b0, "no run");
    endtask

    task automatic wait_irq(input logic v);
        int n;
        for (n = 0; n < 8 && irq !== v; n++)
            tick(1);
        chk(irq === v, "irq level", 1'b1);
    endtask

    task automatic ack();
        irq_ack <= 1'b1;
        tick(1);
        irq_ack <= 1'b0;
        wait_irq(1'b0);
    endtask

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc > 30000)
            chk(1'b0, "run timeout", 1'b1);
    end

    // ==========================================================================
    // Main sequence
    initial
    begin
        void'($urandom(75));
        bad_addr = {10'($urandom_range(1023, 2)), 2'b00};
        tick(5);
        rst <= 1'b0;
        wait_fetch(256);
        chk(clk_sel === 6'h04 && uv_lvl === 2'h2 && uv_det_en === 1'b1, "opt");
        apb(0, `OFS_CTRL_STATUS, 0, `CTRL_STATUS_RESET, 32'h71, 0);
        apb(0, `OFS_SEQ_STATUS, 0, 32'h0a8, 32'h1ff, 0);
        apb(1, bad_addr, $urandom, 0, 0, 1);
        apb(0, bad_addr, 0, 0, 32'hffff_ffff, 1);
        apb(1, `OFS_CTRL_STATUS, 32'h71, 0, 0, 0);
        apb(0, `OFS_CTRL_STATUS, 0, 32'h40, 32'h71, 0);
        wait_i   <= 1'b1;
        warn_cmp <= 1'b1;
        wait_irq(1'b1);
        tick(2);
        chk(wake === 1'b1, "no wake from wait");
        apb(0, `OFS_CTRL_STATUS, 0, 32'h60, 32'h71, 0);
        ack();
        // Halt freezes register, no wake, masked event later
        halt    <= 1'b1;
        cc_mask <= 1'b1;
        tick(2);
        warn_cmp <= 1'b0;
        apb(1, `OFS_CTRL_STATUS, 0, 0, 0, 0);
        apb(0, `OFS_CTRL_STATUS, 0, 32'h60, 32'h71, 0);
        chk(wake === 1'b0 && irq === 1'b0, "woke in halt");
        halt   <= 1'b0;
        wait_i <= 1'b0;
        tick(4);
        chk(irq === 1'b0, "irq while masked");
        cc_mask <= 1'b0;
        wait_irq(1'b1);
        ack();
        // Enabling while below threshold
        apb(1, `OFS_CTRL_STATUS, 0, 0, 0, 0);
        warn_cmp <= 1'b1;
        tick(4);
        chk(irq === 1'b0, "irq while disabled");
        apb(1, `OFS_CTRL_STATUS, 32'h40, 0, 0, 0);
        wait_irq(1'b1);
        ack();
        warn_cmp <= 1'b0;
        wait_irq(1'b1);
        ack();
        // Watchdog underflow
        wdg <= 1'b1;
        tick(1);
        wdg <= 1'b0;
        wait_fetch(306);
        apb(0, `OFS_CTRL_STATUS, 0, 32'h01, 32'h71, 0);
        // Undervoltage, then reassert during delay; warning ends in delay
        uv_det   <= 1'b1;
        warn_cmp <= 1'b1;
        tick(60);
        chk(pin_oe === 1'b1 && board_rst === 1'b1 && cpu_reset === 1'b1, "uv");
        uv_det <= 1'b0;
        tick(50);
        warn_cmp <= 1'b0;
        tick(50);
        uv_det <= 1'b1;
        tick(2);
        uv_det <= 1'b0;
        wait_fetch(256);
        chk(irq === 1'b0, "warning irq from crossing in delay");
        apb(0, `OFS_CTRL_STATUS, 0, 32'h10, 32'h71, 0);
        apb(1, `OFS_CTRL_STATUS, 0, 0, 0, 0);
        apb(0, `OFS_CTRL_STATUS, 0, 0, 32'h71, 0);
        // External pull on the line
        ext_pull <= 1'b1;
        tick(8);
        chk(cpu_reset === 1'b1, "no external reset");
        ext_pull <= 1'b0;
        wait_fetch(256);
        // Long delay, undervoltage option off
        rst      <= 1'b1;
        opts     <= '{1'b1, 1'b0, 2'h1, 3'h5};
        warn_cmp <= 1'b1;
        tick(5);
        rst <= 1'b0;
        wait_fetch(4096);
        chk(clk_sel === 6'h20 && uv_det_en === 1'b0 && uv_lvl === 2'h1, "opt");
        apb(1, `OFS_CTRL_STATUS, 32'h40, 0, 0, 0);
        apb(0, `OFS_CTRL_STATUS, 0, 0, 32'h60, 0);
        print_verdict();
    end
endmodule
